// *** core/drive_ref_core.sv ***
// Reference, jog, up-down and DC braking sequencer with APB registers
// Assumes terminal and run pins are asynchronous; power stage
// scales dcLevelPct by motor rated current.
// What this block does
// - Stop method one decelerates then injects DC
// - Braking begins at brake start frequency
// - Output held off for brake wait time
// - Stop brake level in percent rated current
// - DC applied for brake duration, then stop
// - Zero level or duration disables stop braking
// - Brake gain chosen from load inertia setting
// - Start brake applied before acceleration begins
// - Zero start level or time skips it
// - Code eleven injects DC while stopped
// - Code four with run gives jog frequency
// - Jog overrides multi-step, up-down, 3-wire sources
// - Codes 26/27 are forward/reverse jog runs
// - Up-down reference only with method eight
// - Codes 15 up, 16 down, 25 clear
// - Save select one stores pre-stop frequency
// - Clear ignored while up or down active
// - Mode zero ramps to high/low limits
// - Mode one steps per edge, saves falling
// - Mode two steps, three-second hold ramps
// - All modes share mode zero ramp rates
// - Edges during unfinished step are ignored
`timescale 1ns/1ps
`include "drive_ref_defines.svh"
module drive_ref_core
  import drive_ref_pkg::*;
#(
  parameter int TICK_CYCLES = `TICK_CYCLES
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Terminals, asynchronous
  input wire logic [7:0] termIn,
  input wire logic [1:0] fwd_rev_run_cmd,
  // Power stage command
  output drive_cmd_t driveCmd
);

  function automatic logic anyFunc(input logic [7:0] pins,
    input logic [63:0] sel, input logic [4:0] code);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < 8; i++)
    begin
      if (pins[i] && sel[i*8 +: 5] == code)
        hit = 1'b1;
    end
    return hit;
  endfunction : anyFunc

  function automatic logic [15:0] clampFreq(input logic [15:0] f,
    input logic [15:0] lo, input logic [15:0] hi);
    logic [15:0] r;
    r = f;
    if (r > hi)
      r = hi;
    if (r < lo)
      r = lo;
    return r;
  endfunction : clampFreq

  function automatic logic [15:0] stepTo(input logic [15:0] cur,
    input logic [15:0] tgt, input logic [15:0] rate);
    logic [16:0] up;
    logic [15:0] r;
    up = {1'b0, cur} + {1'b0, rate};
    r = cur;
    if (tgt > cur)
      r = (up >= {1'b0, tgt}) ? tgt : up[15:0];
    else if (tgt < cur)
      r = (cur - tgt <= rate) ? tgt : cur - rate;
    return r;
  endfunction : stepTo

  // Configuration
  logic [11:0] ctrl;
  logic [15:0] brkStart, jogFreq, maxFreq, startFreq, hiLim, loLim;
  logic [15:0] stepFreq, savedFreq, keyRef, rampRate;
  logic [9:0] brkWait, brkDur, stbTime;
  logic [7:0] brkLevel, stbLevel;
  logic [63:0] fsel;

  logic [1:0] stopSel;
  logic [3:0] freqMeth;
  logic [1:0] udMode;
  logic saveSel, limitEn;
  logic [1:0] inertia;
  assign stopSel = ctrl[`CTRL_STOP_LSB +: 2];
  assign freqMeth = ctrl[`CTRL_FMETH_LSB +: 4];
  assign udMode = ctrl[`CTRL_UDMODE_LSB +: 2];
  assign saveSel = ctrl[`CTRL_SAVE_BIT];
  assign inertia = ctrl[`CTRL_INERTIA_LSB +: 2];
  assign limitEn = ctrl[`CTRL_LIMIT_BIT];

  // Two-stage synchronisers; stage one feeds only stage two
  logic [9:0] syncA, syncB, syncPrev;
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      syncA <= 10'h000;
      syncB <= 10'h000;
      syncPrev <= 10'h000;
    end
    else
    begin
      syncA <= {fwd_rev_run_cmd, termIn};
      syncB <= syncA;
      syncPrev <= syncB;
    end
  end

  logic [7:0] term, termPrev;
  logic runFwd, runRev, jogFwd, jogRev, jogTerm, dcStopTerm;
  logic upLvl, dnLvl, clrLvl, upPrev, dnPrev;
  assign term = syncB[7:0];
  assign termPrev = syncPrev[7:0];
  assign runFwd = syncB[8];
  assign runRev = syncB[9];
  assign jogTerm = anyFunc(term, fsel, `FN_JOG);
  assign jogFwd = anyFunc(term, fsel, `FN_JOG_FWD);
  assign jogRev = anyFunc(term, fsel, `FN_JOG_REV);
  assign dcStopTerm = anyFunc(term, fsel, `FN_DC_STOP);
  assign upLvl = anyFunc(term, fsel, `FN_UP);
  assign dnLvl = anyFunc(term, fsel, `FN_DOWN);
  assign clrLvl = anyFunc(term, fsel, `FN_UD_CLEAR);
  assign upPrev = anyFunc(termPrev, fsel, `FN_UP);
  assign dnPrev = anyFunc(termPrev, fsel, `FN_DOWN);

  logic runReq, jogActive, reverse;
  assign runReq = runFwd | runRev | jogFwd | jogRev;
  assign jogActive = (jogTerm & (runFwd | runRev)) | jogFwd | jogRev;
  assign reverse = jogRev | (runRev & ~jogFwd);

  // 10 ms time base
  logic [31:0] preCnt;
  logic tick;
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      preCnt <= 32'h0000_0000;
      tick <= 1'b0;
    end
    else if (preCnt == 32'(TICK_CYCLES - 1))
    begin
      preCnt <= 32'h0000_0000;
      tick <= 1'b1;
    end
    else
    begin
      preCnt <= preCnt + 32'h0000_0001;
      tick <= 1'b0;
    end
  end

  // Frequency target
  seq_state_t state;
  logic [15:0] outFreq, udRef, baseRef, lowBound, highBound, target;
  assign lowBound = limitEn ? loLim : startFreq;
  assign highBound = limitEn ? hiLim : maxFreq;
  always_comb
  begin
    baseRef = (freqMeth == `FMETH_UPDOWN) ? udRef : keyRef;
    if (jogActive)
      target = clampFreq(jogFreq, startFreq, maxFreq);
    else if (baseRef < startFreq)
      target = 16'h0000;
    else
      target = clampFreq(baseRef, lowBound, highBound);
  end

  logic brakeOk, startDcOk;
  logic [15:0] tmr;
  assign brakeOk = stopSel == `STOP_DC && brkLevel != 8'h00
    && brkDur != 10'h000;
  assign startDcOk = stbLevel != 8'h00 && stbTime != 10'h000;

  // Sequencer; a run request during stop braking waits for the end, one during hold DC ends it
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state <= ST_IDLE;
      tmr <= 16'h0000;
    end
    else
    begin
      if (tick)
        tmr <= tmr + 16'h0001;
      case (state)
        ST_IDLE:
        begin
          tmr <= 16'h0000;
          if (runReq)
            state <= startDcOk ? ST_START_DC : ST_RUN;
          else if (dcStopTerm)
            state <= ST_HOLD_DC;
        end
        ST_START_DC:
          if (tmr >= 16'(stbTime * `TICKS_PER_TENTH_S))
            state <= ST_RUN;
        ST_RUN:
          if (!runReq)
            state <= (stopSel == `STOP_FREE) ? ST_IDLE : ST_DECEL;
        ST_DECEL:
        begin
          tmr <= 16'h0000;
          if (runReq)
            state <= ST_RUN;
          else if (brakeOk && outFreq <= brkStart)
            state <= ST_BRK_WAIT;
          else if (outFreq == 16'h0000)
            state <= ST_IDLE;
        end
        ST_BRK_WAIT:
          if (tmr >= 16'(brkWait * `TICKS_PER_TENTH_S))
          begin
            state <= ST_BRK_DC;
            tmr <= 16'h0000;
          end
        ST_BRK_DC:
          if (tmr >= 16'(brkDur * `TICKS_PER_TENTH_S))
            state <= ST_IDLE;
        ST_HOLD_DC:
          if (!dcStopTerm || runReq)
            state <= ST_IDLE;
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  // Output frequency ramp, one rate for all sources
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      outFreq <= 16'h0000;
    else if (state == ST_RUN && tick)
      outFreq <= stepTo(outFreq, target, rampRate);
    else if (state == ST_DECEL && tick)
      outFreq <= stepTo(outFreq, 16'h0000, rampRate);
    else if (state != ST_RUN && state != ST_DECEL)
      outFreq <= 16'h0000;
  end

  // Up-down reference
  logic upRise, dnRise, upFall, dnFall, stepBusy, contRamp;
  logic [9:0] holdCnt;
  logic [16:0] udSum;
  assign upRise = upLvl & ~upPrev;
  assign dnRise = dnLvl & ~dnPrev;
  assign upFall = ~upLvl & upPrev;
  assign dnFall = ~dnLvl & dnPrev;
  assign stepBusy = state == ST_RUN && outFreq != target;
  assign contRamp = udMode == 2'h0
    || (udMode == 2'h2 && holdCnt >= 10'(`UD_HOLD_TICKS));
  assign udSum = {1'b0, udRef} + {1'b0, stepFreq};

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      holdCnt <= 10'h000;
    else if (!(upLvl ^ dnLvl))
      holdCnt <= 10'h000;
    else if (tick && holdCnt < 10'(`UD_HOLD_TICKS))
      holdCnt <= holdCnt + 10'h001;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      udRef <= `RST_SAVED;
    else if (clrLvl && !upLvl && !dnLvl)
      udRef <= 16'h0000;
    else if (contRamp && tick && upLvl && !dnLvl)
      udRef <= stepTo(udRef, highBound, rampRate);
    else if (contRamp && tick && dnLvl && !upLvl)
      udRef <= stepTo(udRef, lowBound, rampRate);
    else if (udMode != 2'h0 && upRise && !stepBusy)
      udRef <= udSum > {1'b0, highBound} ? highBound : udSum[15:0];
    else if (udMode != 2'h0 && dnRise && !stepBusy)
      udRef <= ({1'b0, udRef} < {1'b0, lowBound} + {1'b0, stepFreq})
        ? lowBound : udRef - stepFreq;
  end

  // Drive command, registered
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      driveCmd <= '0;
    else
    begin
      driveCmd.freq <= outFreq;
      driveCmd.reverse <= reverse;
      driveCmd.gateOff <= state != ST_RUN && state != ST_DECEL;
      driveCmd.dcInject <= state == ST_START_DC || state == ST_BRK_DC
        || state == ST_HOLD_DC;
      driveCmd.dcLevelPct <= (state == ST_BRK_DC) ? brkLevel
        : stbLevel;
      case (inertia)
        2'h0: driveCmd.dcGain <= `GAIN_LOW;
        2'h1: driveCmd.dcGain <= `GAIN_MID;
        default: driveCmd.dcGain <= `GAIN_HIGH;
      endcase
    end
  end

  // APB slave: one setup, one access cycle
  logic wrEn, mapped;
  logic [31:0] rdMux;
  assign wrEn = psel & penable & pready & pwrite;
  always_comb
  begin
    mapped = 1'b1;
    rdMux = 32'h0000_0000;
    case (paddr)
      `REG_CTRL: rdMux = {20'h00000, ctrl};
      `REG_BRK_START: rdMux = {16'h0000, brkStart};
      `REG_BRK_WAIT: rdMux = {22'h000000, brkWait};
      `REG_BRK_LEVEL: rdMux = {24'h000000, brkLevel};
      `REG_BRK_DUR: rdMux = {22'h000000, brkDur};
      `REG_STB_LEVEL: rdMux = {24'h000000, stbLevel};
      `REG_STB_TIME: rdMux = {22'h000000, stbTime};
      `REG_JOG: rdMux = {16'h0000, jogFreq};
      `REG_MAX: rdMux = {16'h0000, maxFreq};
      `REG_STARTF: rdMux = {16'h0000, startFreq};
      `REG_HI_LIM: rdMux = {16'h0000, hiLim};
      `REG_LO_LIM: rdMux = {16'h0000, loLim};
      `REG_STEP: rdMux = {16'h0000, stepFreq};
      `REG_SAVED: rdMux = {16'h0000, savedFreq};
      `REG_FSEL_LO: rdMux = fsel[31:0];
      `REG_FSEL_HI: rdMux = fsel[63:32];
      `REG_KEYREF: rdMux = {16'h0000, keyRef};
      `REG_RAMP: rdMux = {16'h0000, rampRate};
      `REG_STATUS: rdMux = {12'h000, driveCmd.dcInject, state, outFreq};
      `REG_UDREF: rdMux = {16'h0000, udRef};
      default: mapped = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel & ~penable & ~pready;
      prdata <= (psel & ~penable & ~pwrite) ? rdMux : 32'h0000_0000;
      pslverr <= psel & ~penable & ~mapped;
    end
  end

  // Saved up-down frequency; hardware events win over a bus write
  logic runPrev;
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      runPrev <= 1'b0;
    else
      runPrev <= runReq;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      savedFreq <= `RST_SAVED;
    else if (clrLvl && !upLvl && !dnLvl)
      savedFreq <= 16'h0000;
    else if (saveSel && udMode == 2'h1 && (upFall || dnFall))
      savedFreq <= udRef;
    else if (saveSel && udMode != 2'h1 && runPrev && !runReq)
      savedFreq <= udRef;
    else if (wrEn && paddr == `REG_SAVED)
      savedFreq <= pwdata[15:0];
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ctrl <= `RST_CTRL;
      brkStart <= `RST_BRK_START;
      brkWait <= `RST_BRK_WAIT;
      brkLevel <= `RST_BRK_LEVEL;
      brkDur <= `RST_BRK_DUR;
      stbLevel <= `RST_STB_LEVEL;
      stbTime <= `RST_STB_TIME;
      jogFreq <= `RST_JOG;
      maxFreq <= `RST_MAX;
      startFreq <= `RST_STARTF;
      hiLim <= `RST_HI_LIM;
      loLim <= `RST_LO_LIM;
      stepFreq <= `RST_STEP;
      fsel <= {`RST_FSEL_HI, `RST_FSEL_LO};
      keyRef <= `RST_KEYREF;
      rampRate <= `RST_RAMP;
    end
    else if (wrEn)
    begin
      case (paddr)
        `REG_CTRL: ctrl <= pwdata[11:0];
        `REG_BRK_START: brkStart <= pwdata[15:0];
        `REG_BRK_WAIT: brkWait <= pwdata[9:0];
        `REG_BRK_LEVEL: brkLevel <= pwdata[7:0];
        `REG_BRK_DUR: brkDur <= pwdata[9:0];
        `REG_STB_LEVEL: stbLevel <= pwdata[7:0];
        `REG_STB_TIME: stbTime <= pwdata[9:0];
        `REG_JOG: jogFreq <= pwdata[15:0];
        `REG_MAX: maxFreq <= pwdata[15:0];
        `REG_STARTF: startFreq <= pwdata[15:0];
        `REG_HI_LIM: hiLim <= pwdata[15:0];
        `REG_LO_LIM: loLim <= pwdata[15:0];
        `REG_STEP: stepFreq <= pwdata[15:0];
        `REG_FSEL_LO: fsel[31:0] <= pwdata;
        `REG_FSEL_HI: fsel[63:32] <= pwdata;
        `REG_KEYREF: keyRef <= pwdata[15:0];
        `REG_RAMP: rampRate <= pwdata[15:0];
        default: ;
      endcase
    end
  end

endmodule : drive_ref_core

// *** shared/drive_ref_defines.svh ***
// Register offsets, field positions, reset values and timing counts
// Assumes a 100 MHz clock and frequencies in 0.01 Hz units
`ifndef DRIVE_REF_DEFINES_SVH
`define DRIVE_REF_DEFINES_SVH
`define CLK_MHZ 100
`define TICK_US 10000
`define TICK_CYCLES (`TICK_US * `CLK_MHZ)
`define TICKS_PER_TENTH_S (100000 / `TICK_US)
`define UD_HOLD_MS 3000
`define UD_HOLD_TICKS ((`UD_HOLD_MS * 1000) / `TICK_US)
`define REG_CTRL 8'h00
`define REG_BRK_START 8'h04
`define REG_BRK_WAIT 8'h08
`define REG_BRK_LEVEL 8'h0C
`define REG_BRK_DUR 8'h10
`define REG_STB_LEVEL 8'h14
`define REG_STB_TIME 8'h18
`define REG_JOG 8'h1C
`define REG_MAX 8'h20
`define REG_STARTF 8'h24
`define REG_HI_LIM 8'h28
`define REG_LO_LIM 8'h2C
`define REG_STEP 8'h30
`define REG_SAVED 8'h34
`define REG_FSEL_LO 8'h38
`define REG_FSEL_HI 8'h3C
`define REG_KEYREF 8'h40
`define REG_RAMP 8'h44
`define REG_STATUS 8'h48
`define REG_UDREF 8'h4C
`define CTRL_STOP_LSB 0
`define CTRL_FMETH_LSB 2
`define CTRL_UDMODE_LSB 6
`define CTRL_SAVE_BIT 8
`define CTRL_INERTIA_LSB 9
`define CTRL_LIMIT_BIT 11
`define RST_CTRL 12'h000
`define RST_BRK_START 16'h01F4
`define RST_BRK_WAIT 10'h001
`define RST_BRK_LEVEL 8'h32
`define RST_BRK_DUR 10'h00A
`define RST_STB_LEVEL 8'h32
`define RST_STB_TIME 10'h000
`define RST_JOG 16'h03E8
`define RST_MAX 16'h1770
`define RST_STARTF 16'h0032
`define RST_HI_LIM 16'h1770
`define RST_LO_LIM 16'h0032
`define RST_STEP 16'h0000
`define RST_SAVED 16'h0000
`define RST_FSEL_LO 32'h0302_0100
`define RST_FSEL_HI 32'h0706_0504
`define RST_KEYREF 16'h0000
`define RST_RAMP 16'h000A
`define STOP_DC 2'h1
`define STOP_FREE 2'h2
`define FMETH_UPDOWN 4'h8
`define FN_JOG 5'h04
`define FN_DC_STOP 5'h0B
`define FN_UP 5'h0F
`define FN_DOWN 5'h10
`define FN_UD_CLEAR 5'h19
`define FN_JOG_FWD 5'h1A
`define FN_JOG_REV 5'h1B
`define GAIN_LOW 8'h10
`define GAIN_MID 8'h20
`define GAIN_HIGH 8'h40
`endif

// *** shared/drive_ref_pkg.sv ***
// Types shared by the reference and braking sequencer
// Assumes frequencies in 0.01 Hz units and levels in percent
package drive_ref_pkg;
  typedef enum logic [2:0] {
    ST_IDLE, ST_START_DC, ST_RUN, ST_DECEL, ST_BRK_WAIT, ST_BRK_DC,
    ST_HOLD_DC
  } seq_state_t;
  typedef struct packed {
    logic [15:0] freq;
    logic reverse;
    logic gateOff;
    logic dcInject;
    logic [7:0] dcLevelPct;
    logic [7:0] dcGain;
  } drive_cmd_t;
endpackage : drive_ref_pkg

// *** verif/dc_brake_jog_updown_frequency_ref_tb_top.sv ***
// Self-checking bench for the reference and braking sequencer
// Assumes the partner model drives the pins; 10-cycle tick
`timescale 1ns/1ps
`include "drive_ref_defines.svh"
module dc_brake_jog_updown_frequency_ref_tb_top
  import drive_ref_pkg::*;
;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00, reqTerm = 8'h00, termIn;
  logic [31:0] pwdata = 32'h0, prdata, dcTotal, lastDcLen, rdv, t0;
  logic pready, pslverr, errv;
  logic [1:0] reqRun = 2'h0, fwd_rev_run_cmd;
  drive_cmd_t driveCmd;
  logic [15:0] kref, lvl, jog, step, lo;
  int seed = 32'h78B9;
  int fails = 0, compares = 0, cycles = 0;
  logic [7:0] regAddr [5] = '{`REG_BRK_START, `REG_BRK_WAIT,
    `REG_BRK_LEVEL, `REG_BRK_DUR, `REG_JOG};
  logic [31:0] regRst [5] = '{`RST_BRK_START, `RST_BRK_WAIT,
    `RST_BRK_LEVEL, `RST_BRK_DUR, `RST_JOG};
  // Short tick keeps braking times within a quick run
  localparam int TB_TICK = 10;
  localparam int BRK_CYC = `RST_BRK_DUR * `TICKS_PER_TENTH_S * TB_TICK;
  localparam int STB_CYC = `TICKS_PER_TENTH_S * TB_TICK;
  drive_ref_core #(.TICK_CYCLES(TB_TICK)) dut (.clk, .arst_n, .psel,
    .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .termIn,
    .fwd_rev_run_cmd, .driveCmd);
  drive_partner_model partner (.clk, .arst_n, .reqTerm, .reqRun, .termIn,
    .fwd_rev_run_cmd, .driveCmd, .dcTotal, .lastDcLen);
  always #5 clk = ~clk;
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 80000)
    begin
      fails++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // No cycle count assumed; only the bench timeout ends this wait
    do
      @(posedge clk);
    while (pready !== 1'b1);
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rdv, e);
  endtask : rd
  // Bounded wait, then the frequency itself is compared
  task automatic waitF(input logic [15:0] f);
    for (int i = 0; i < 6000; i++)
    begin
      @(posedge clk);
      if (driveCmd.freq === f)
        break;
    end
    chk(driveCmd.freq, f);
  endtask : waitF
  task automatic waitDc(input logic v);
    for (int i = 0; i < 3000; i++)
    begin
      @(posedge clk);
      if (driveCmd.dcInject === v)
        break;
    end
    chk(driveCmd.dcInject, v);
  endtask : waitDc
  task automatic pulse(input logic [7:0] t);
    @(posedge clk);
    reqTerm <= t;
    repeat (6) @(posedge clk);
    reqTerm <= 8'h00;
  endtask : pulse
  function automatic logic [7:0] gainFor(input int i);
    return (i == 0) ? `GAIN_LOW : (i == 1) ? `GAIN_MID : `GAIN_HIGH;
  endfunction : gainFor
  function automatic logic [15:0] udExp(input logic [15:0] s, input int n);
    return 16'(s * n);
  endfunction : udExp
  initial
  begin
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    for (int i = 0; i < 5; i++)
      rd(regAddr[i], regRst[i]);
    apb(1'b0, 8'h80, 32'h0);
    chk(rdv, 32'h0);
    chk(errv, 1'b1);
    wr(`REG_FSEL_LO, 32'h100F_040B);
    wr(`REG_FSEL_HI, 32'h001B_1A19);
    wr(`REG_RAMP, 32'h0000_0064);
    for (int i = 0; i < 3; i++)
    begin
      wr(`REG_CTRL, 32'(i) << `CTRL_INERTIA_LSB);
      repeat (3) @(posedge clk);
      chk(driveCmd.dcGain, gainFor(i));
    end
    kref = 16'h0800 | 16'($random(seed) & 32'h07FF);
    lvl = 16'h0001 + 16'($unsigned($random(seed)) % 200);
    wr(`REG_KEYREF, 32'(kref));
    wr(`REG_BRK_LEVEL, 32'(lvl));
    wr(`REG_CTRL, 32'h0000_0001);
    reqRun <= 2'h1;
    waitF(kref);
    reqRun <= 2'h0;
    waitDc(1'b1);
    chk(driveCmd.dcLevelPct, lvl);
    chk(driveCmd.gateOff, 1'b1);
    waitDc(1'b0);
    chk(lastDcLen >= BRK_CYC - TB_TICK && lastDcLen <= BRK_CYC + TB_TICK,
      1'b1);
    // Zero duration must leave the stop plain
    wr(`REG_BRK_DUR, 32'h0);
    t0 = dcTotal;
    reqRun <= 2'h1;
    waitF(kref);
    reqRun <= 2'h0;
    repeat (800) @(posedge clk);
    chk(dcTotal, t0);
    wr(`REG_BRK_DUR, 32'h0000_000A);
    lvl = 16'h0001 + 16'($unsigned($random(seed)) % 200);
    wr(`REG_CTRL, 32'h0);
    wr(`REG_STB_LEVEL, 32'(lvl));
    wr(`REG_STB_TIME, 32'h1);
    reqRun <= 2'h1;
    waitDc(1'b1);
    chk(driveCmd.dcLevelPct, lvl);
    waitDc(1'b0);
    chk(lastDcLen >= STB_CYC - TB_TICK && lastDcLen <= STB_CYC + TB_TICK,
      1'b1);
    waitF(kref);
    reqRun <= 2'h0;
    waitF(16'h0000);
    wr(`REG_STB_TIME, 32'h0);
    t0 = dcTotal;
    reqRun <= 2'h1;
    waitF(kref);
    chk(dcTotal, t0);
    reqRun <= 2'h0;
    waitF(16'h0000);
    reqTerm <= 8'h01;
    repeat (8) @(posedge clk);
    chk(driveCmd.dcInject, 1'b1);
    chk(driveCmd.dcLevelPct, lvl);
    reqTerm <= 8'h00;
    jog = 16'h0100 | 16'($random(seed) & 32'h0FFF);
    wr(`REG_JOG, 32'(jog));
    wr(`REG_CTRL, 32'h0000_0020);
    reqTerm <= 8'h02;
    reqRun <= 2'h1;
    waitF(jog);
    reqTerm <= 8'h00;
    reqRun <= 2'h0;
    waitF(16'h0000);
    for (int i = 0; i < 2; i++)
    begin
      reqTerm <= 8'(8'h20 << i);
      waitF(jog);
      chk(driveCmd.reverse, i[0]);
      reqTerm <= 8'h00;
      waitF(16'h0000);
    end
    step = 16'h0190 + 16'($unsigned($random(seed)) % 100);
    wr(`REG_STEP, 32'(step));
    wr(`REG_CTRL, 32'h0000_0160);
    reqRun <= 2'h1;
    for (int i = 1; i <= 3; i++)
    begin
      pulse(8'h04);
      waitF(udExp(step, i));
    end
    // Second edge lands while the first step still ramps
    pulse(8'h04);
    pulse(8'h04);
    waitF(udExp(step, 4));
    repeat (100) @(posedge clk);
    rd(`REG_UDREF, 32'(udExp(step, 4)));
    pulse(8'h08);
    waitF(udExp(step, 3));
    reqRun <= 2'h0;
    waitF(16'h0000);
    rd(`REG_SAVED, 32'(udExp(step, 3)));
    pulse(8'h10);
    repeat (5) @(posedge clk);
    rd(`REG_SAVED, 32'h0);
    wr(`REG_CTRL, 32'h0000_01A0);
    reqRun <= 2'h1;
    reqTerm <= 8'h04;
    waitF(`RST_MAX);
    reqTerm <= 8'h00;
    lo = 16'h0100 + 16'($unsigned($random(seed)) % 512);
    wr(`REG_LO_LIM, 32'(lo));
    wr(`REG_CTRL, 32'h0000_0920);
    reqTerm <= 8'h08;
    waitF(lo);
    reqTerm <= 8'h00;
    reqRun <= 2'h0;
    waitF(16'h0000);
    rd(`REG_SAVED, 32'(lo));
    give_verdict();
  end
endmodule : dc_brake_jog_updown_frequency_ref_tb_top

// *** verif/drive_partner_model.sv ***
// Terminal contacts and power stage beside the sequencer
// Assumes the bench sets requested contact levels
`timescale 1ns/1ps
module drive_partner_model
  import drive_ref_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Bench requests
  input wire logic [7:0] reqTerm,
  input wire logic [1:0] reqRun,
  // Pins toward the sequencer
  output logic [7:0] termIn,
  output logic [1:0] fwd_rev_run_cmd,
  // Power stage side
  input wire drive_cmd_t driveCmd,
  output logic [31:0] dcTotal,
  output logic [31:0] lastDcLen
);
  logic [31:0] runLen;
  initial
  begin
    termIn = 8'h00;
    fwd_rev_run_cmd = 2'h0;
  end
  // Contacts move only on the clock edge
  always @(posedge clk)
  begin
    termIn <= reqTerm;
    fwd_rev_run_cmd <= reqRun;
  end
  // Injection time as the power stage sees it
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      dcTotal <= 32'h0;
      runLen <= 32'h0;
      lastDcLen <= 32'h0;
    end
    else if (driveCmd.dcInject)
    begin
      dcTotal <= dcTotal + 32'h1;
      runLen <= runLen + 32'h1;
      lastDcLen <= runLen + 32'h1;
    end
    else
      runLen <= 32'h0;
  end
endmodule : drive_partner_model

// *** verif/drive_ref_monitor.sv ***
// Port-level checks on the reference and braking sequencer
// Assumes one clock domain; bound to every drive_ref_core
`timescale 1ns/1ps
module drive_ref_monitor
  import drive_ref_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Power stage command
  input wire drive_cmd_t driveCmd
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  sequence setupPhase;
    psel && !penable;
  endsequence
  sequence accessDone;
    psel && penable && pready;
  endsequence
  a_ready_after_setup: assert property (setupPhase |=> accessDone)
    else $error("no answer in the first access cycle");
  a_ready_single: assert property (pready |=> !pready)
    else $error("ready held longer than one cycle");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("error flag without ready");
  a_rdata_quiet: assert property (!pready |-> prdata == 32'h0000_0000)
    else $error("read data outside the access cycle");
  a_dc_gate_off: assert property (driveCmd.dcInject |-> driveCmd.gateOff)
    else $error("DC injected while modulating");
  a_dc_zero_freq: assert property (
    driveCmd.dcInject |-> driveCmd.freq == 16'h0000)
    else $error("DC injected with output frequency");
  a_dc_level_set: assert property (
    driveCmd.dcInject |-> driveCmd.dcLevelPct != 8'h00)
    else $error("DC injected at zero level");
  a_gain_code: assert property ($past(arst_n) |->
    driveCmd.dcGain inside {8'h10, 8'h20, 8'h40})
    else $error("gain code outside the inertia table");
endmodule : drive_ref_monitor

bind drive_ref_core drive_ref_monitor mon (.clk, .arst_n, .psel,
  .penable, .prdata, .pready, .pslverr, .driveCmd);
